// [design/rhpm_defs.svh]
// offsets, field positions and reset values of the port power mask register
`ifndef RHPM_DEFS_SVH
`define RHPM_DEFS_SVH

`define RHPM_REG_OFFSET     8'h4C
`define RHPM_PPIM_LSB       16
`define RHPM_PPIM_MSB       31
`define RHPM_FDM_LSB        0
`define RHPM_FDM_MSB        15
`define RHPM_RESET_VALUE    32'h0006_0000
`define RHPM_NUM_PORTS      2
`define RHPM_MASK_WIDTH     16

`endif

// [design/rhpm_pkg.sv]
// types shared by the port power mask register files
`default_nettype none
package rhpm_pkg;

   typedef struct packed {
      logic [15:0] port_power_individual_mask;
      logic [15:0] fixed_device_mask;
   } rhpm_reg_t;

   typedef enum logic [1:0] {
      RHPM_CMD_NONE   = 2'b00,
      RHPM_CMD_SET    = 2'b01,
      RHPM_CMD_CLEAR  = 2'b10
   } rhpm_cmd_t;

endpackage
`default_nettype wire

// [design/rhpm_ctrl_if.sv]
// carrier between the register and the per-port power steering
`default_nettype none
interface rhpm_ctrl_if #(
   parameter int NUM_PORTS = 2
);
   logic [NUM_PORTS:1] individual_mask;
   logic               per_port_mode;

   modport regs  (output individual_mask, output per_port_mode);
   modport steer (input  individual_mask, input  per_port_mode);
endinterface
`default_nettype wire

// [design/rhpm_power_steer.sv]
// per-port power state under global and per-port commands
`default_nettype none
`include "rhpm_defs.svh"
module rhpm_power_steer #(
   parameter int NUM_PORTS = `RHPM_NUM_PORTS
) (
   input  wire logic                ref_clk_in,
   input  wire logic                rst_n_in,
   rhpm_ctrl_if.steer               ctrl,
   input  wire logic                always_powered_in,
   input  wire logic [1:0]          global_cmd_in,
   input  wire logic [NUM_PORTS:1]  port_set_in,
   input  wire logic [NUM_PORTS:1]  port_clear_in,
   output logic      [NUM_PORTS:1]  port_power_out
);
   typedef struct packed {
      logic [NUM_PORTS:1] power;
   } rhpm_steer_state_t;

   rhpm_steer_state_t state;
   rhpm_steer_state_t next_state;
   logic              gset;
   logic              gclr;
   logic              indiv;

   assign gset = global_cmd_in == rhpm_pkg::RHPM_CMD_SET;
   assign gclr = global_cmd_in == rhpm_pkg::RHPM_CMD_CLEAR;

   always_comb begin
      next_state = state;
      indiv = 1'b0;
      for (int p = 1; p <= NUM_PORTS; p++) begin
         indiv = ctrl.per_port_mode & ctrl.individual_mask[p];
         if (always_powered_in) begin
            next_state.power[p] = 1'b1;
         end else if (indiv) begin
            if (port_set_in[p]) begin
               next_state.power[p] = 1'b1;
            end else if (port_clear_in[p]) begin
               next_state.power[p] = 1'b0;
            end
         end else if (gset) begin
            next_state.power[p] = 1'b1;
         end else if (gclr) begin
            next_state.power[p] = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign port_power_out = state.power;
endmodule
`default_nettype wire

// [design/rhpm_top.sv]
// root hub port power mask and removable device register with power steering
`default_nettype none
`include "rhpm_defs.svh"
module rhpm_top #(
   parameter int        NUM_PORTS   = `RHPM_NUM_PORTS,
   parameter logic [31:0] RESET_VALUE = `RHPM_RESET_VALUE
) (
   input  wire logic                ref_clk_in,
   input  wire logic                rstn_in,
   input  wire logic                reg_sel_in,
   input  wire logic [7:0]          reg_addr_in,
   input  wire logic                reg_wr_in,
   input  wire logic [3:0]          reg_be_in,
   input  wire logic [31:0]         reg_wdata_in,
   output logic      [31:0]         reg_rdata_out,
   input  wire logic                individual_power_switching_select_in,
   input  wire logic                always_powered_select_in,
   input  wire logic [1:0]          global_cmd_in,
   input  wire logic [NUM_PORTS:1]  port_set_in,
   input  wire logic [NUM_PORTS:1]  port_clear_in,
   output logic      [NUM_PORTS:1]  port_power_out,
   output logic      [NUM_PORTS:1]  port_fixed_out
);
   // refuse port counts that the 16-bit masks cannot describe
   if (NUM_PORTS < 1 || NUM_PORTS > `RHPM_MASK_WIDTH - 1) begin : g_bad_ports
      $error("rhpm_top: NUM_PORTS out of range");
   end

   typedef struct packed {
      rhpm_pkg::rhpm_reg_t regs;
      logic [31:0]        rdata;
      logic [NUM_PORTS:1] fixed;
   } rhpm_top_state_t;

   rhpm_top_state_t state;
   rhpm_top_state_t next_state;
   logic            rst_n;
   logic            hit;
   logic [31:0]     cur;
   logic [31:0]     wr_val;

   // reset release through two flops; only this process sees the raw pin
   logic [1:0] rst_pipe;
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   rhpm_ctrl_if #(.NUM_PORTS(NUM_PORTS)) ctrl ();

   // per-port mode counts only while ports are switched
   assign ctrl.per_port_mode = individual_power_switching_select_in
                             & ~always_powered_select_in;
   assign ctrl.individual_mask =
      state.regs.port_power_individual_mask[NUM_PORTS:1];

   assign hit = reg_sel_in && reg_addr_in == `RHPM_REG_OFFSET;
   assign cur = state.regs;

   always_comb begin
      next_state = state;
      wr_val = cur;
      for (int b = 0; b < 4; b++) begin
         if (reg_be_in[b]) begin
            wr_val[b*8 +: 8] = reg_wdata_in[b*8 +: 8];
         end
      end
      if (hit && reg_wr_in) begin
         next_state.regs = wr_val;
      end
      next_state.rdata = (hit && !reg_wr_in) ? cur : 32'h0000_0000;
      next_state.fixed =
         state.regs.fixed_device_mask[NUM_PORTS:1];
   end

   always_ff @(posedge ref_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state.regs     <= RESET_VALUE;
         state.rdata    <= 32'h0000_0000;
         state.fixed    <= '0;
      end else begin
         state <= next_state;
      end
   end

   rhpm_power_steer #(.NUM_PORTS(NUM_PORTS)) u_steer (
      .ref_clk_in        (ref_clk_in),
      .rst_n_in          (rst_n),
      .ctrl              (ctrl.steer),
      .always_powered_in (always_powered_select_in),
      .global_cmd_in     (global_cmd_in),
      .port_set_in       (port_set_in),
      .port_clear_in     (port_clear_in),
      .port_power_out    (port_power_out)
   );

   assign reg_rdata_out  = state.rdata;
   assign port_fixed_out = state.fixed;
endmodule
`default_nettype wire

// [verif/rhpm_checker.sv]
// port-level assertions for the port power mask register
`default_nettype none
module rhpm_checker #(parameter int NUM_PORTS = 2) (
   input wire logic                ref_clk_in,
   input wire logic                rstn_in,
   input wire logic                reg_sel_in,
   input wire logic [7:0]          reg_addr_in,
   input wire logic                reg_wr_in,
   input wire logic [31:0]         reg_rdata_out,
   input wire logic                individual_power_switching_select_in,
   input wire logic                always_powered_select_in,
   input wire logic [1:0]          global_cmd_in,
   input wire logic [NUM_PORTS:1]  port_power_out,
   input wire logic [NUM_PORTS:1]  port_fixed_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   wire logic hit = reg_sel_in && reg_addr_in == 8'h4C;
   wire logic wr_hit = hit && reg_wr_in;
   wire logic gang = !individual_power_switching_select_in
                     && !always_powered_select_in;
   a_idle_reads_zero: assert property (!reg_sel_in |=> reg_rdata_out == 0)
      else $error("read data not zero while idle");
   a_miss_reads_zero: assert property (reg_sel_in && !hit |=> reg_rdata_out == 0)
      else $error("unmapped access returned data");
   a_write_no_data: assert property (wr_hit |=> reg_rdata_out == 0)
      else $error("write returned read data");
   a_ganged_set: assert property (gang && global_cmd_in == 2'h1 |=> &port_power_out)
      else $error("global set missed a port");
   a_ganged_clear: assert property (gang && global_cmd_in == 2'h2 |=> port_power_out == 0)
      else $error("global clear missed a port");
   a_ganged_port_cmd: assert property (gang && global_cmd_in == 2'h0 |=> $stable(port_power_out))
      else $error("port power moved without global command");
   a_always_on: assert property (always_powered_select_in [*2] |-> &port_power_out)
      else $error("always powered ports are off");
   a_fixed_after_write: assert property ($changed(port_fixed_out) |-> $past(wr_hit) || $past(wr_hit, 2))
      else $error("fixed flags changed without a write");
   c_read: cover property (hit && !reg_wr_in);
   c_ganged: cover property (gang && global_cmd_in == 2'h1);
   c_individual: cover property (individual_power_switching_select_in && global_cmd_in == 2'h1);
endmodule
bind rhpm_top rhpm_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);
`default_nettype wire

// [verif/rhpm_test.sv]
// self-checking bench for the port power mask register
`default_nettype none
module rhpm_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_in = 0, rstn_in = 0, reg_sel_in = 0, reg_wr_in = 0;
   logic        individual_power_switching_select_in = 0;
   logic        always_powered_select_in = 0;
   logic [7:0]  reg_addr_in = 8'h00;
   logic [3:0]  reg_be_in = 4'h0;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
   logic [1:0]  global_cmd_in = 2'h0;
   logic [2:1]  port_set_in = 2'h0, port_clear_in = 2'h0;
   logic [2:1]  port_power_out, port_fixed_out;
   logic [31:0] fx [4] = '{32'h1, 32'h2, 32'h4, 32'hFFFF_FFF8};
   int          err_total = 0, checks = 0;
   rhpm_top i_dut (.*);
   always #5 ref_clk_in = ~ref_clk_in;
   task automatic chk(input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk_in);
      reg_sel_in <= 1'b1;
      reg_wr_in <= w;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_be_in <= be;
      @(posedge ref_clk_in);
      reg_sel_in <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0, 4'h0);
      chk(reg_rdata_out, e);
   endtask
   task automatic cmd(input logic [1:0] g, s, c, e);
      @(posedge ref_clk_in);
      global_cmd_in <= g;
      port_set_in <= s;
      port_clear_in <= c;
      @(posedge ref_clk_in);
      global_cmd_in <= 2'h0;
      port_set_in <= 2'h0;
      port_clear_in <= 2'h0;
      #1;
      chk(port_power_out, e);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_in);
      rstn_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      rd(8'h4C, 32'h0006_0000);
      acc(1'b1, 8'h48, 32'hFFFF_FFFF, 4'hF);
      rd(8'h48, 32'h0);
      rd(8'h4C, 32'h0006_0000);
      acc(1'b1, 8'h4C, 32'hFFFF_FFFF, 4'hF);
      acc(1'b1, 8'h4C, 32'h0, 4'h2);
      rd(8'h4C, 32'hFFFF_00FF);
      foreach (fx[i]) begin
         acc(1'b1, 8'h4C, fx[i], 4'hF);
         @(posedge ref_clk_in);
         #1;
         chk(port_fixed_out, fx[i][2:1]);
      end
      cmd(2'h1, 2'h0, 2'h0, 2'h3);
      cmd(2'h0, 2'h0, 2'h3, 2'h3);
      cmd(2'h2, 2'h0, 2'h0, 2'h0);
      acc(1'b1, 8'h4C, 32'hFFFA_0000, 4'hF);
      @(posedge ref_clk_in);
      individual_power_switching_select_in <= 1'b1;
      cmd(2'h1, 2'h0, 2'h0, 2'h2);
      cmd(2'h0, 2'h3, 2'h0, 2'h3);
      cmd(2'h2, 2'h0, 2'h0, 2'h1);
      cmd(2'h0, 2'h2, 2'h0, 2'h1);
      cmd(2'h0, 2'h0, 2'h3, 2'h0);
      @(posedge ref_clk_in);
      always_powered_select_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      #1;
      chk(port_power_out, 2'h3);
      give_verdict;
   end
endmodule
`default_nettype wire
